//--- serial_port_map.vh
// Constants and field positions for the serial command port.
// Behaviour
// - After a full command arrives, drop request-to-send while the command is processed.
// - Responses to queries or triggers start only once processing has finished.
// - While a response is pending or sent, refuse reception and hold request-to-send low.
// - Raise request-to-send again once the response has fully gone out.
// - Send while clear-to-send is active, pause while it is inactive.
// - Abandon the response if clear-to-send stays inactive beyond about one second.
// - XON and XOFF characters are plain data, never flow control.
// - Only one of serial port and parallel bus is active; first message wins.
// - Interface selection is freed only by return to local or power cycle.
// - Transmitted messages end in CR LF at power-on; delimiter command may change it.
// - Buffer readout on the serial port always returns ASCII form.
// - Remote-request command puts the device in remote state under serial control.
// - The front-panel local key returns the device to local state.
// - Operation-complete commands and queries are still accepted on the serial port.
// - Message-available bit 3 and query-error bit 2 are unused on serial.
`ifndef SERIAL_PORT_MAP_VH
`define SERIAL_PORT_MAP_VH
`define CLOCK_HZ 100000000
`define BAUD_DEFAULT 4800
`define CTS_TIMEOUT_MS 1000
`define CTS_TIMEOUT_CYCLES ((`CLOCK_HZ / 1000) * `CTS_TIMEOUT_MS)
`define CHAR_CR 8'h0d
`define CHAR_LF 8'h0a
`define DLM_CRLF 2'h0
`define DLM_CR 2'h1
`define DLM_LF 2'h2
`define DLM_NONE 2'h3
`define STB_MAV_BIT 3
`define ESR_QYE_BIT 2
`define SEL_NONE 2'h0
`define SEL_SERIAL 2'h1
`define SEL_PARALLEL 2'h2
`endif

//--- serial_frame_tx.v
// Asynchronous character transmitter with configurable frame.
`timescale 1ns/1ps
module serial_frame_tx #(
    parameter DIV_W = 16
) (
    // Clock and reset.
    input wire clock,
    input wire reset_n,
    // Frame configuration.
    input wire [DIV_W-1:0] bit_div,
    input wire eight_bits,
    input wire parity_en,
    input wire parity_odd,
    input wire two_stop,
    // Character stream.
    input wire char_valid,
    input wire [7:0] char_data,
    output wire char_ready,
    // Serial line.
    output reg txd
);
    reg [DIV_W-1:0] div_reg;
    reg [3:0] left_reg;
    reg [11:0] shift_reg;
    reg busy_reg;
    wire par_bit;
    wire [7:0] data_used;

    assign data_used = eight_bits ? char_data : {1'b0, char_data[6:0]};
    assign par_bit = (^data_used) ^ parity_odd;
    assign char_ready = ~busy_reg;

    // Shift the frame out LSB first; data bits, parity and stop bits are built at load.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            div_reg <= {DIV_W{1'b0}};
            left_reg <= 4'h0;
            shift_reg <= 12'hfff;
            busy_reg <= 1'b0;
            txd <= 1'b1;
        end else if (!busy_reg) begin
            txd <= 1'b1;
            if (char_valid) begin
                busy_reg <= 1'b1;
                div_reg <= bit_div;
                txd <= 1'b0;
                if (eight_bits) begin
                    shift_reg <= parity_en ? {2'h3, par_bit, char_data, 1'b0} :
                                             {3'h7, char_data, 1'b0};
                end else begin
                    shift_reg <= parity_en ? {3'h7, par_bit, char_data[6:0], 1'b0} :
                                             {4'hf, char_data[6:0], 1'b0};
                end
                left_reg <= 4'd8 + {3'h0, eight_bits} + {3'h0, parity_en} +
                            {3'h0, two_stop};
            end
        end else if (div_reg != {DIV_W{1'b0}}) begin
            div_reg <= div_reg - 1'b1;
        end else if (left_reg == 4'h0) begin
            busy_reg <= 1'b0;
            txd <= 1'b1;
        end else begin
            div_reg <= bit_div;
            shift_reg <= {1'b1, shift_reg[11:1]};
            txd <= shift_reg[1];
            left_reg <= left_reg - 1'b1;
        end
    end
endmodule

//--- serial_command_port.v
// Serial command port: receiver, RTS/CTS handshake, response sequencing and remote state.
`timescale 1ns/1ps
`include "serial_port_map.vh"
module serial_command_port #(
    parameter DIV_W = 16,
    parameter CTS_TIMEOUT = `CTS_TIMEOUT_CYCLES
) (
    // Clock and reset.
    input wire clock,
    input wire reset_n,
    // Frame configuration from the setup menu.
    input wire [DIV_W-1:0] bit_div,
    input wire eight_bits,
    input wire parity_en,
    input wire parity_odd,
    input wire two_stop,
    // Serial pins.
    input wire rxd,
    output wire txd,
    output reg rts,
    input wire cts,
    // Received command characters to the parser.
    output reg cmd_char_valid,
    output reg [7:0] cmd_char,
    output reg cmd_done,
    output reg parity_error,
    // Parser results for the completed command.
    input wire proc_done,
    input wire resp_expected,
    input wire remote_request_cmd,
    input wire delimiter_select_cmd,
    input wire [1:0] delimiter_code,
    input wire buffer_readout_query,
    // Response characters without delimiter.
    input wire resp_valid,
    input wire [7:0] resp_char,
    input wire resp_last,
    output wire resp_ready,
    // Remote state and interface arbitration.
    input wire local_key,
    input wire parallel_msg,
    output reg remote,
    output reg [1:0] active_if,
    output wire force_ascii,
    output wire stb_mav_enable,
    output wire esr_qye_enable,
    output reg tx_abandoned
);
    localparam ST_IDLE = 5'h01;
    localparam ST_PROC = 5'h02;
    localparam ST_SEND = 5'h04;
    localparam ST_DLM1 = 5'h08;
    localparam ST_DLM2 = 5'h10;

    reg [4:0] state_reg;
    reg [4:0] state_next;
    reg [1:0] dlm_reg;
    reg [31:0] cts_cnt_reg;
    reg prev_cr_reg;
    // Receiver.
    reg rx_s1_reg;
    reg rx_s2_reg;
    reg rx_busy_reg;
    reg [DIV_W-1:0] rx_div_reg;
    reg [3:0] rx_bit_reg;
    reg [9:0] rx_sh_reg;
    wire [3:0] rx_total;
    wire [9:0] rx_aligned;
    wire rx_sample;
    wire [7:0] rx_char;
    wire rx_par_ok;
    // Transmit path.
    reg tx_valid;
    reg [7:0] tx_char;
    wire tx_ready;
    wire cts_stalled;

    // Data width and parity together give the bits shifted in after the start bit.
    function [3:0] frame_bits;
        input eb;
        input pe;
        begin
            frame_bits = 4'd7 + {3'h0, eb} + {3'h0, pe};
        end
    endfunction

    assign rx_total = frame_bits(eight_bits, parity_en);
    assign rx_sample = rx_busy_reg && (rx_div_reg == {DIV_W{1'b0}});
    // Bits enter at the top, so the frame is shifted down until the first data bit is bit 0.
    assign rx_aligned = rx_sh_reg >> (4'd10 - rx_total);
    assign rx_char = eight_bits ? rx_aligned[7:0] : {1'b0, rx_aligned[6:0]};
    assign rx_par_ok = !parity_en ||
        (((^rx_char) ^ parity_odd) == (eight_bits ? rx_aligned[8] : rx_aligned[7]));
    assign cts_stalled = !cts;
    assign force_ascii = buffer_readout_query;
    assign stb_mav_enable = 1'b0;
    assign esr_qye_enable = 1'b0;

    // The receive line is synchronised first; only the second stage is examined.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
        end else begin
            rx_s1_reg <= rxd;
            rx_s2_reg <= rx_s1_reg;
        end
    end

    // Receiver samples mid-bit; characters are only accepted while idle and RTS is high.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rx_busy_reg <= 1'b0;
            rx_div_reg <= {DIV_W{1'b0}};
            rx_bit_reg <= 4'h0;
            rx_sh_reg <= 10'h000;
            cmd_char_valid <= 1'b0;
            cmd_char <= 8'h00;
            parity_error <= 1'b0;
        end else begin
            cmd_char_valid <= 1'b0;
            parity_error <= 1'b0;
            if (!rx_busy_reg) begin
                if (!rx_s2_reg) begin
                    rx_busy_reg <= 1'b1;
                    rx_div_reg <= {1'b0, bit_div[DIV_W-1:1]};
                    rx_bit_reg <= 4'h0;
                end
            end else if (!rx_sample) begin
                rx_div_reg <= rx_div_reg - 1'b1;
            end else begin
                rx_div_reg <= bit_div;
                rx_bit_reg <= rx_bit_reg + 1'b1;
                if (rx_bit_reg == 4'h0) begin
                    rx_busy_reg <= !rx_s2_reg;
                end else if (rx_bit_reg <= rx_total) begin
                    rx_sh_reg <= {rx_s2_reg, rx_sh_reg[9:1]};
                end else begin
                    rx_busy_reg <= 1'b0;
                    // Characters arriving outside the idle state are dropped, not queued.
                    if (state_reg == ST_IDLE && rts && active_if != `SEL_PARALLEL) begin
                        cmd_char_valid <= rx_par_ok;
                        cmd_char <= rx_char;
                        parity_error <= !rx_par_ok;
                    end
                end
            end
        end
    end

    // A command ends when a line feed directly follows a carriage return.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prev_cr_reg <= 1'b0;
            cmd_done <= 1'b0;
        end else begin
            cmd_done <= 1'b0;
            if (cmd_char_valid) begin
                prev_cr_reg <= (cmd_char == `CHAR_CR);
                cmd_done <= prev_cr_reg && (cmd_char == `CHAR_LF);
            end
        end
    end

    // Command sequencing: process, then optionally respond, then reopen reception.
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (cmd_done) begin
                    state_next = ST_PROC;
                end
            end
            ST_PROC: begin
                if (proc_done) begin
                    state_next = resp_expected ? ST_SEND : ST_IDLE;
                end
            end
            ST_SEND: begin
                if (cts_cnt_reg >= CTS_TIMEOUT) begin
                    state_next = ST_IDLE;
                end else if (resp_valid && resp_last && tx_ready && !cts_stalled) begin
                    state_next = (dlm_reg == `DLM_NONE) ? ST_IDLE : ST_DLM1;
                end
            end
            ST_DLM1: begin
                if (cts_cnt_reg >= CTS_TIMEOUT) begin
                    state_next = ST_IDLE;
                end else if (tx_ready && !cts_stalled) begin
                    state_next = (dlm_reg == `DLM_CRLF) ? ST_DLM2 : ST_IDLE;
                end
            end
            ST_DLM2: begin
                if (cts_cnt_reg >= CTS_TIMEOUT || (tx_ready && !cts_stalled)) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Pick the character handed to the transmitter this cycle.
    always @* begin
        tx_valid = 1'b0;
        tx_char = resp_char;
        case (state_reg)
            ST_SEND: begin
                tx_valid = resp_valid && !cts_stalled;
            end
            ST_DLM1: begin
                tx_valid = !cts_stalled;
                tx_char = (dlm_reg == `DLM_LF) ? `CHAR_LF : `CHAR_CR;
            end
            ST_DLM2: begin
                tx_valid = !cts_stalled;
                tx_char = `CHAR_LF;
            end
            default: begin
                tx_valid = 1'b0;
            end
        endcase
    end

    assign resp_ready = (state_reg == ST_SEND) && tx_ready && !cts_stalled;

    // State, RTS and the CTS inactivity timer.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
            rts <= 1'b1;
            cts_cnt_reg <= 32'h0000_0000;
            tx_abandoned <= 1'b0;
        end else begin
            state_reg <= state_next;
            // RTS stays low from command end until processing ends without a reply, or the last reply character is out, or the CTS timeout abandons it.
            // A character handed over on this edge keeps it low, so no one-cycle glitch.
            rts <= (state_next == ST_IDLE) && tx_ready && !tx_valid;
            tx_abandoned <= (state_reg != ST_IDLE) && (state_reg != ST_PROC) &&
                            (cts_cnt_reg >= CTS_TIMEOUT);
            if (cts || state_reg == ST_IDLE || state_reg == ST_PROC) begin
                cts_cnt_reg <= 32'h0000_0000;
            end else if (cts_cnt_reg < CTS_TIMEOUT) begin
                cts_cnt_reg <= cts_cnt_reg + 32'h0000_0001;
            end
        end
    end

    // Delimiter, remote state and interface selection.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dlm_reg <= `DLM_CRLF;
            remote <= 1'b0;
            active_if <= `SEL_NONE;
        end else begin
            if (proc_done && state_reg == ST_PROC && delimiter_select_cmd) begin
                dlm_reg <= delimiter_code;
            end
            // Operation-complete commands pass through the parser untouched.
            if (local_key) begin
                remote <= 1'b0;
                active_if <= `SEL_NONE;
            end else begin
                if (proc_done && state_reg == ST_PROC && remote_request_cmd) begin
                    remote <= 1'b1;
                end
                if (active_if == `SEL_NONE) begin
                    if (cmd_done) begin
                        active_if <= `SEL_SERIAL;
                    end else if (parallel_msg) begin
                        active_if <= `SEL_PARALLEL;
                    end
                end
            end
        end
    end

    serial_frame_tx #(
        .DIV_W(DIV_W)
    ) u_tx (
        .clock(clock),
        .reset_n(reset_n),
        .bit_div(bit_div),
        .eight_bits(eight_bits),
        .parity_en(parity_en),
        .parity_odd(parity_odd),
        .two_stop(two_stop),
        .char_valid(tx_valid),
        .char_data(tx_char),
        .char_ready(tx_ready),
        .txd(txd)
    );
endmodule

//--- serial_port_monitor.sv
// Checker for the handshake, arbitration and state outputs of the serial command port.
`timescale 1ns/1ps
module serial_port_monitor #(
    parameter CTS_TIMEOUT = 2000
) (
    // Clock and reset.
    input wire clock,
    input wire reset_n,
    // Serial lines.
    input wire txd,
    input wire rts,
    input wire cts,
    // Command side.
    input wire cmd_char_valid,
    input wire cmd_done,
    input wire buffer_readout_query,
    input wire force_ascii,
    // State and arbitration.
    input wire local_key,
    input wire remote,
    input wire [1:0] active_if,
    input wire tx_abandoned
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    reg [31:0] cts_low_reg;
    // Counts cycles with sending held back, so an abandon can be timed against the limit.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cts_low_reg <= 32'h0;
        end else begin
            cts_low_reg <= cts ? 32'h0 : cts_low_reg + 32'h1;
        end
    end
    property p_rts_drop;
        cmd_done |=> !rts;
    endproperty
    a_rts_drop: assert property (p_rts_drop) else $error("rts high after command end");
    property p_rts_idle;
        $rose(rts) |-> txd;
    endproperty
    a_rts_idle: assert property (p_rts_idle) else $error("rts high while sending");
    property p_no_early_tx;
        cmd_done |=> txd [*8];
    endproperty
    a_no_early_tx: assert property (p_no_early_tx) else $error("reply before done");
    property p_refuse;
        (!rts && $past(!rts)) |-> !cmd_char_valid;
    endproperty
    a_refuse: assert property (p_refuse) else $error("character taken while busy");
    property p_cts_pause;
        (!cts) [*8] |-> !$fell(txd);
    endproperty
    a_cts_pause: assert property (p_cts_pause) else $error("start bit while held");
    property p_timeout;
        tx_abandoned |-> (cts_low_reg >= CTS_TIMEOUT - 1 && cts_low_reg <= CTS_TIMEOUT + 8);
    endproperty
    a_timeout: assert property (p_timeout) else $error("abandon at wrong time");
    property p_abandon_rts;
        tx_abandoned |-> ##[0:4] rts;
    endproperty
    a_abandon_rts: assert property (p_abandon_rts) else $error("rts low after abandon");
    property p_keep_owner;
        (active_if != 2'h0 && !local_key) |=> $stable(active_if);
    endproperty
    a_keep_owner: assert property (p_keep_owner) else $error("owner changed");
    property p_local;
        local_key |=> (!remote && active_if == 2'h0);
    endproperty
    a_local: assert property (p_local) else $error("local key ignored");
    property p_ascii;
        force_ascii == buffer_readout_query;
    endproperty
    a_ascii: assert property (p_ascii) else $error("readout form wrong");
endmodule
bind serial_command_port serial_port_monitor #(.CTS_TIMEOUT(CTS_TIMEOUT)) i_monitor (
    .clock(clock), .reset_n(reset_n), .txd(txd), .rts(rts), .cts(cts),
    .cmd_char_valid(cmd_char_valid), .cmd_done(cmd_done),
    .buffer_readout_query(buffer_readout_query), .force_ascii(force_ascii),
    .local_key(local_key), .remote(remote), .active_if(active_if), .tx_abandoned(tx_abandoned));

//--- host_port.sv
// Host computer serial port model with hardware handshake lines.
`timescale 1ns/1ps
module host_port (
    // Clock and bit timing.
    input wire clock,
    input wire [15:0] bit_div,
    // Serial pins, named from the device side.
    output reg rxd,
    input wire txd,
    input wire rts,
    output reg cts
);
    reg [7:0] got_q[$];
    reg [7:0] sh;
    integer j;
    // The line idles at mark and the host drives its handshake line itself.
    initial begin
        rxd = 1'b1;
        cts = 1'b1;
    end
    task bit_wait;
        repeat (bit_div + 1) @(posedge clock);
    endtask
    // Start bit, eight data bits from the low end, one stop bit.
    task send_char(input [7:0] c);
        integer k;
        begin
            rxd <= 1'b0;
            bit_wait();
            for (k = 0; k < 8; k = k + 1) begin
                rxd <= c[k];
                bit_wait();
            end
            rxd <= 1'b1;
            bit_wait();
        end
    endtask
    // A command waits up to 5000 cycles for the device to listen, so no reply is talked over.
    task send_cmd(input [7:0] c);
        integer k;
        begin
            for (k = 0; k < 5000 && !rts; k = k + 1) @(posedge clock);
            send_char(c);
            send_char(8'h0d);
            send_char(8'h0a);
        end
    endtask
    // Receiver samples each bit in its middle and keeps every character.
    always begin
        @(negedge txd);
        repeat ((bit_div + 1) / 2) @(posedge clock);
        for (j = 0; j < 8; j = j + 1) begin
            bit_wait();
            sh[j] = txd;
        end
        bit_wait();
        got_q.push_back(sh);
    end
endmodule

//--- serial_command_port_flow_control_bench.sv
// Self-checking bench for the serial command port against a host model.
`timescale 1ns/1ps
module serial_command_port_flow_control_bench;
    localparam TMO = 200;
    reg clock = 1'b0;
    reg reset_n = 1'b0;
    reg proc_done = 1'b0;
    reg resp_expected = 1'b0;
    reg remote_request_cmd = 1'b0;
    reg delimiter_select_cmd = 1'b0;
    reg [1:0] delimiter_code = 2'h0;
    reg buffer_readout_query = 1'b0;
    reg resp_valid = 1'b0;
    reg [7:0] resp_char = 8'h00;
    reg resp_last = 1'b0;
    reg local_key = 1'b0;
    reg parallel_msg = 1'b0;
    reg [15:0] bit_div = 16'h0003;
    reg eight_bits = 1'b1;
    reg parity_en = 1'b0;
    reg parity_odd = 1'b0;
    reg two_stop = 1'b0;
    wire rxd, txd, rts, cts, cmd_char_valid, cmd_done, parity_error, resp_ready;
    wire remote, force_ascii, stb_mav_enable, esr_qye_enable, tx_abandoned;
    wire [7:0] cmd_char;
    wire [1:0] active_if;
    integer failures = 0;
    integer cmp_count = 0;
    integer n;
    integer tally;
    always #5 clock = ~clock;
    // Frame is fixed at eight data bits, no parity, four clocks a bit to keep runs short.
    serial_command_port #(.CTS_TIMEOUT(TMO)) i_dut (.clock(clock), .reset_n(reset_n),
        .bit_div(bit_div), .eight_bits(eight_bits), .parity_en(parity_en),
        .parity_odd(parity_odd), .two_stop(two_stop), .rxd(rxd), .txd(txd), .rts(rts), .cts(cts),
        .cmd_char_valid(cmd_char_valid), .cmd_char(cmd_char), .cmd_done(cmd_done),
        .parity_error(parity_error), .proc_done(proc_done), .resp_expected(resp_expected),
        .remote_request_cmd(remote_request_cmd), .delimiter_select_cmd(delimiter_select_cmd),
        .delimiter_code(delimiter_code), .buffer_readout_query(buffer_readout_query),
        .resp_valid(resp_valid), .resp_char(resp_char), .resp_last(resp_last),
        .resp_ready(resp_ready), .local_key(local_key), .parallel_msg(parallel_msg),
        .remote(remote), .active_if(active_if), .force_ascii(force_ascii),
        .stb_mav_enable(stb_mav_enable), .esr_qye_enable(esr_qye_enable),
        .tx_abandoned(tx_abandoned));
    host_port i_host (.clock(clock), .bit_div(bit_div), .rxd(rxd), .txd(txd), .rts(rts),
        .cts(cts));
    task check(input [31:0] seen, input [31:0] exp, input string what);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                $display("unexpected %s expected %h seen %h", what, exp, seen);
                failures = failures + 1;
            end
        end
    endtask
    task finish_test;
        begin
            if (failures == 0 && cmp_count > 0) begin
                $display("NO MISMATCHES");
            end else begin
                $display("MISMATCHES SEEN");
            end
            $finish;
        end
    endtask
    // A wait that ran out of cycles ends the run as a failure.
    task give_up(input integer k, input integer lim);
        if (k >= lim) begin
            failures = failures + 1;
            finish_test;
        end
    endtask
    task command(input [7:0] c);
        begin
            i_host.send_cmd(c);
            for (n = 0; n < 200 && !cmd_done; n = n + 1) @(posedge clock);
            give_up(n, 200);
            @(posedge clock);
        end
    endtask
    task processed(input resp, input dsel, input [1:0] code);
        begin
            proc_done <= 1'b1;
            resp_expected <= resp;
            delimiter_select_cmd <= dsel;
            delimiter_code <= code;
            @(posedge clock);
            proc_done <= 1'b0;
            delimiter_select_cmd <= 1'b0;
        end
    endtask
    // The character is held until the edge that samples ready high.
    task send_resp(input [7:0] c, input last);
        begin
            resp_valid <= 1'b1;
            resp_char <= c;
            resp_last <= last;
            @(posedge clock);
            for (n = 0; n < 3000 && !resp_ready; n = n + 1) @(posedge clock);
            give_up(n, 3000);
        end
    endtask
    task collect(input [31:0] exp, input [2:0] cnt);
        integer k;
        begin
            for (n = 0; n < 3000 && !rts; n = n + 1) @(posedge clock);
            give_up(n, 3000);
            check(i_host.got_q.size(), cnt, "reply count");
            for (k = 0; k < cnt; k = k + 1)
                check(i_host.got_q[k], exp[8*(cnt-1-k) +: 8], "reply byte");
            i_host.got_q.delete();
        end
    endtask
    task pulse_local;
        begin
            local_key <= 1'b1;
            @(posedge clock);
            local_key <= 1'b0;
            @(posedge clock);
        end
    endtask
    // Query with refused traffic, a held-off reply and an in-band XOFF byte.
    task run_query;
        begin
            command(8'h3f);
            check({rts, active_if}, 3'h1, "busy owner");
            tally = 0;
            fork
                i_host.send_char(8'h55);
                repeat (70) begin
                    @(posedge clock);
                    tally = tally + cmd_char_valid + rts + !txd;
                end
            join
            check(tally, 32'h0, "refused rx");
            i_host.cts <= 1'b0;
            remote_request_cmd <= 1'b1;
            processed(1'b1, 1'b0, 2'h0);
            remote_request_cmd <= 1'b0;
            tally = 0;
            fork
                begin
                    send_resp(8'h13, 1'b0);
                    send_resp(8'h11, 1'b1);
                    resp_valid <= 1'b0;
                end
                begin
                    repeat (40) begin
                        @(posedge clock);
                        tally = tally + !txd;
                    end
                    i_host.cts <= 1'b1;
                end
            join
            check(tally, 32'h0, "cts pause");
            check(remote, 1'h1, "remote");
            collect(32'h13110d0a, 3'h4);
        end
    endtask
    // Reply held back past the limit is dropped and the port listens again.
    task run_timeout;
        begin
            command(8'h54);
            i_host.cts <= 1'b0;
            resp_valid <= 1'b1;
            resp_char <= 8'h54;
            resp_last <= 1'b0;
            processed(1'b1, 1'b0, 2'h0);
            for (n = 0; n < 400 && !tx_abandoned; n = n + 1) @(posedge clock);
            give_up(n, 400);
            check(n >= TMO - 3, 1'h1, "cts wait");
            resp_valid <= 1'b0;
            i_host.cts <= 1'b1;
            collect(32'h0, 3'h0);
        end
    endtask
    // Local key, parallel ownership, reselection and a changed delimiter.
    task run_local_parallel;
        begin
            pulse_local;
            check({remote, active_if}, 3'h0, "local");
            parallel_msg <= 1'b1;
            buffer_readout_query <= 1'b1;
            @(posedge clock);
            parallel_msg <= 1'b0;
            @(posedge clock);
            check({active_if, force_ascii, stb_mav_enable, esr_qye_enable}, 5'h14, "par");
            tally = 0;
            fork
                i_host.send_cmd(8'h3f);
                repeat (170) begin
                    @(posedge clock);
                    tally = tally + cmd_done + cmd_char_valid;
                end
            join
            check(tally, 32'h0, "serial refused");
            pulse_local;
            buffer_readout_query <= 1'b0;
            command(8'h2a);
            check(active_if, 2'h1, "reselect");
            processed(1'b0, 1'b1, 2'h2);
            repeat (20) @(posedge clock);
            command(8'h3f);
            processed(1'b1, 1'b0, 2'h0);
            send_resp(8'h5a, 1'b1);
            resp_valid <= 1'b0;
            collect(32'h5a0a, 3'h2);
        end
    endtask
    initial begin
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        check({rts, txd, remote}, 3'h6, "reset state");
        run_query;
        run_timeout;
        run_local_parallel;
        finish_test;
    end
endmodule
